// [e3oh_buf.sv]
// two-entry buffer between the framer's overhead bytes and the serialiser
// assumes both sides run on sys_clk; read data come from the entry registers
`timescale 1ns/10ps
module e3oh_buf #(
    parameter int W = 9
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic [W-1:0] mem [2];
    logic [W-1:0] next_mem [2];
    logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [1:0] count, next_count;
    logic next_in_ready;
    logic push, pop;

    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push) begin
            next_mem[wr_ptr] = in_data;
            next_wr_ptr = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
        next_count = count + {1'b0, push} - {1'b0, pop};
        next_in_ready = (next_count != 2'h2);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            in_ready <= 1'b1;
        end else begin
            mem <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready <= next_in_ready;
        end
    end
endmodule : e3oh_buf

// [e3oh_pkg.sv]
// constants for the receive overhead serial output port of one e3 channel
// shared by the port module and the testbench; the two-entry byte buffer only gets BUF_W as a parameter
package e3oh_pkg;
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int OH_CLK_PERIOD_NS = 400;
    localparam int OH_HALF_RAW = OH_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
    localparam int OH_HALF_CYC = (OH_HALF_RAW < 1) ? 1 : OH_HALF_RAW;
    localparam int FRAME_BYTES = 537;
    localparam int OH_BYTES = 7;
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] BITS_AFTER_MSB = 3'h7;
    localparam logic [2:0] BIT_NONE = 3'h0;
    localparam logic [2:0] BYTE_IDX_DONE = 3'h7;
    localparam logic [2:0] BYTE_IDX_FIRST = 3'h1;
    localparam logic [7:0] DIV_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int BUF_W = 9;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01
    } e3oh_state_e;
endpackage : e3oh_pkg

// [e3oh_serial_out.sv]
// receive overhead serial output port, dedicated overhead clock mode
// assumes overhead bytes arrive from the framer on sys_clk, tagged first at fa1
`timescale 1ns/10ps
module e3oh_serial_out #(
    parameter int HALF_CYC = e3oh_pkg::OH_HALF_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic oh_in_valid,
    input wire logic [7:0] oh_in_byte,
    input wire logic oh_in_first,
    output logic oh_in_ready,
    output logic overhead_serial_out,
    output logic overhead_bit_clock,
    output logic overhead_frame_marker
);
    import e3oh_pkg::*;

    logic [7:0] div_cnt, next_div_cnt;
    logic next_oh_clk;
    logic fall_tick;
    e3oh_state_e state, next_state;
    logic [7:0] shreg, next_shreg;
    logic [2:0] bit_left, next_bit_left;
    logic [2:0] byte_idx, next_byte_idx;
    logic next_data, next_mark;
    logic buf_valid, buf_pop, load, discard;
    logic [BUF_W-1:0] buf_dout;
    logic buf_first;
    logic [7:0] buf_byte;

    // small buffer so a late serialiser never loses a byte from the framer
    e3oh_buf #(.W(BUF_W)) u_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(oh_in_valid),
        .in_data({oh_in_first, oh_in_byte}),
        .in_ready(oh_in_ready),
        .out_valid(buf_valid),
        .out_data(buf_dout),
        .out_ready(buf_pop)
    );

    assign buf_first = buf_dout[BUF_W-1];
    assign buf_byte = buf_dout[7:0];

    // free-running divider; falls only from high so data moves on falling edges
    always_comb begin
        if (div_cnt == 8'(HALF_CYC - 1)) begin
            next_div_cnt = DIV_ZERO;
            next_oh_clk = ~overhead_bit_clock;
        end else begin
            next_div_cnt = div_cnt + 8'h01;
            next_oh_clk = overhead_bit_clock;
        end
        fall_tick = (div_cnt == 8'(HALF_CYC - 1)) && overhead_bit_clock;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_cnt <= DIV_ZERO;
            overhead_bit_clock <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            overhead_bit_clock <= next_oh_clk;
        end
    end

    // bytes past the seventh of a frame are dropped until the next fa1
    always_comb begin
        discard = buf_valid && !buf_first && (byte_idx == 3'(OH_BYTES));
        load = fall_tick && buf_valid && !discard
            && (state == ST_IDLE || bit_left == BIT_NONE);
        buf_pop = discard || load;
        next_state = state;
        next_shreg = shreg;
        next_bit_left = bit_left;
        next_byte_idx = byte_idx;
        next_data = overhead_serial_out;
        next_mark = overhead_frame_marker;
        if (fall_tick) begin
            if (state == ST_SHIFT && bit_left != BIT_NONE) begin
                next_data = shreg[7];
                next_shreg = {shreg[6:0], 1'b0};
                next_bit_left = bit_left - 3'h1;
                next_mark = 1'b0;
            end else if (load) begin
                next_state = ST_SHIFT;
                next_data = buf_byte[7];
                next_shreg = {buf_byte[6:0], 1'b0};
                next_bit_left = BITS_AFTER_MSB;
                next_mark = buf_first;
                next_byte_idx = buf_first ? BYTE_IDX_FIRST : byte_idx + 3'h1;
            end else begin
                // underrun: idle zeros keep the pin driven, never floated
                next_state = ST_IDLE;
                next_data = 1'b0;
                next_mark = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            shreg <= BYTE_ZERO;
            bit_left <= BIT_NONE;
            byte_idx <= BYTE_IDX_DONE;
            overhead_serial_out <= 1'b0;
            overhead_frame_marker <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bit_left <= next_bit_left;
            byte_idx <= next_byte_idx;
            overhead_serial_out <= next_data;
            overhead_frame_marker <= next_mark;
        end
    end

    // helper: cycles since the overhead clock last changed
    logic [7:0] run_len;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            run_len <= DIV_ZERO;
        end else if (next_oh_clk != overhead_bit_clock) begin
            run_len <= DIV_ZERO;
        end else begin
            run_len <= run_len + 8'h01;
        end
    end

    // helper: cycles the frame marker has stood high so far
    logic [7:0] mark_len;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mark_len <= DIV_ZERO;
        end else if (overhead_frame_marker) begin
            mark_len <= mark_len + 8'h01;
        end else begin
            mark_len <= DIV_ZERO;
        end
    end

    // helper: bits begun in the current frame; idle fill is not counted, so an
    // underrun between bytes does not upset the byte alignment seen here
    logic [5:0] frame_bit;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            frame_bit <= 6'h00;
        end else if (load && buf_first) begin
            frame_bit <= 6'h01;
        end else if (load || (fall_tick && state == ST_SHIFT && bit_left != BIT_NONE)) begin
            frame_bit <= frame_bit + 6'h01;
        end
    end

    a_clk_never_stops: assert property (@(posedge sys_clk) disable iff (!rst_n)
        run_len < 8'(HALF_CYC))
        else $error("overhead clock held too long");

    // both halves of the overhead clock are the same length
    a_clk_even_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(overhead_bit_clock) |-> $past(run_len) == 8'(HALF_CYC - 1))
        else $error("overhead clock half period uneven");

    a_data_on_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !$fell(overhead_bit_clock) |-> $stable(overhead_serial_out))
        else $error("serial data moved off a falling edge");

    a_shift_next_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fall_tick && state == ST_SHIFT && bit_left != BIT_NONE
        |=> overhead_serial_out == $past(shreg[7]) && bit_left == $past(bit_left) - 3'h1)
        else $error("overhead bit not shifted out");

    a_load_msb_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        load |=> overhead_serial_out == $past(buf_byte[7])
            && overhead_frame_marker == $past(buf_first))
        else $error("byte not started with its msb");

    a_byte_eight_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
        load |-> (state == ST_IDLE || bit_left == BIT_NONE) ##1 bit_left == BITS_AFTER_MSB)
        else $error("byte loaded before eight bits were sent");

    // a later byte may only start on a byte boundary and inside the 56 bit slots
    a_byte_boundary: assert property (@(posedge sys_clk) disable iff (!rst_n)
        load && !buf_first |-> frame_bit[2:0] == 3'h0
            && frame_bit < 6'(OH_BYTES * BYTE_BITS))
        else $error("overhead byte started off a byte boundary");

    // marker moves only with a falling clock; a counter measures the high time
    // so the check scales with HALF_CYC without a long repetition
    a_marker_one_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(overhead_frame_marker) |-> $fell(overhead_bit_clock)
            && (overhead_frame_marker || mark_len == 8'(2 * HALF_CYC)))
        else $error("frame marker not exactly one clock period");

    a_marker_resets_index: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(overhead_frame_marker) |-> byte_idx == BYTE_IDX_FIRST)
        else $error("marker not at first overhead byte");

    a_seven_bytes_max: assert property (@(posedge sys_clk) disable iff (!rst_n)
        byte_idx == 3'(OH_BYTES) && buf_valid && !buf_first
        |-> buf_pop && !load ##1 byte_idx == 3'(OH_BYTES))
        else $error("eighth overhead byte not dropped");

    a_idle_drives_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fall_tick && !load && !(state == ST_SHIFT && bit_left != BIT_NONE)
        |=> !overhead_serial_out && !overhead_frame_marker)
        else $error("idle bit not driven low");
endmodule : e3oh_serial_out

// [e3oh_term_model.sv]
// terminal-side model of the overhead port: finds clock rises on sys_clk
// assumes sys_clk runs at least four times faster than the overhead clock
`timescale 1ns/10ps
module e3oh_term_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic oh_data,
    input wire logic oh_clk,
    input wire logic oh_mark,
    output logic rx_valid,
    output logic rx_first,
    output logic [7:0] rx_byte
);
    logic clk_d;
    logic [5:0] cnt;
    logic [5:0] c;
    logic [7:0] sh;
    // saturate so counts past the last bit are ignored
    assign c = oh_mark ? 6'h00 : ((cnt == 6'h3F) ? cnt : cnt + 6'h01);
    always @(posedge sys_clk) begin
        clk_d <= oh_clk;
        rx_valid <= 1'b0;
        if (!rst_n) begin
            cnt <= 6'h3F;
        end else if (oh_clk && !clk_d) begin
            sh <= {sh[6:0], oh_data};
            cnt <= c;
            if (c < 6'h38 && c[2:0] == 3'h7) begin
                rx_valid <= 1'b1;
                rx_byte <= {sh[6:0], oh_data};
                rx_first <= (c == 6'h07);
            end
        end
    end
endmodule : e3oh_term_model

// [tb.sv]
// testbench: feeds overhead bytes, checks the serial port via a terminal model
// assumes e3oh_pkg, e3oh_buf, e3oh_serial_out and e3oh_term_model compiled first
`timescale 1ns/10ps
module tb;
    import e3oh_pkg::*;
    localparam int HC = 4;
    logic sys_clk, rst_n, in_valid, in_first, oh_in_ready, sd, sclk, smark;
    logic rx_valid, rx_first, sd_d, sclk_d, meas;
    logic [7:0] in_byte;
    logic [7:0] rx_byte;
    logic [8:0] exp_q[$];
    int failures = 0, n_checks = 0, frames = 0, rises = 0, stalls = 0, bad = 0, unk = 0;

    e3oh_serial_out #(.HALF_CYC(HC)) u_e3oh_serial_out (.sys_clk(sys_clk), .rst_n(rst_n),
        .oh_in_valid(in_valid), .oh_in_byte(in_byte), .oh_in_first(in_first),
        .oh_in_ready(oh_in_ready), .overhead_serial_out(sd), .overhead_bit_clock(sclk),
        .overhead_frame_marker(smark));
    e3oh_term_model u_e3oh_term_model (.sys_clk(sys_clk), .rst_n(rst_n), .oh_data(sd),
        .oh_clk(sclk), .oh_mark(smark), .rx_valid(rx_valid), .rx_first(rx_first),
        .rx_byte(rx_byte));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic cmp_byte(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t byte %h expected %h", $time, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            failures++;
            $display("ERROR %0t count %0d expected %0d", $time, got, exp);
        end
    endtask : cmp_cnt

    // holds the byte until ready is seen at a sampling edge
    task automatic send(input logic [7:0] b, input logic f, input bit keep);
        int i;
        bit ok;
        i = 0;
        in_valid <= 1'b1;
        in_byte <= b;
        in_first <= f;
        do begin
            @(negedge sys_clk);
            ok = (oh_in_ready === 1'b1);
            @(posedge sys_clk);
            i++;
        end while (!ok && i < 2000);
        if (!ok) begin
            failures++;
            end_sim();
        end
        if (keep) exp_q.push_back({f, b});
    endtask : send

    task automatic frame(input bit extra);
        send(8'($urandom), 1'b1, 1'b1);
        repeat (6) send(8'($urandom), 1'b0, 1'b1);
        if (extra) send(8'($urandom), 1'b0, 1'b0);
        in_valid <= 1'b0;
        repeat (1 + $urandom_range(40)) @(posedge sys_clk);
    endtask : frame

    always @(posedge sys_clk) begin
        sd_d <= sd;
        sclk_d <= sclk;
        if (rst_n === 1'b1 && sd !== sd_d && !(sclk_d === 1'b1 && sclk === 1'b0)) bad++;
        if (meas && sclk === 1'b1 && sclk_d === 1'b0) rises++;
        if (rst_n === 1'b1 && sd !== 1'b0 && sd !== 1'b1) unk++;
        if (in_valid && oh_in_ready === 1'b0) stalls++;
        if (rx_valid === 1'b1) begin
            if (rx_first === 1'b1) frames++;
            cmp_byte({rx_first, rx_byte}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
        end
    end

    initial begin
        rst_n = 1'b0;
        in_valid = 1'b0;
        in_first = 1'b0;
        in_byte = 8'h00;
        meas = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        void'($urandom(36872));
        // stray bytes before any first byte must never reach the pin
        send(8'h5A, 1'b0, 1'b0);
        send(8'hA5, 1'b0, 1'b0);
        in_valid <= 1'b0;
        @(posedge sys_clk);
        for (int f = 0; f < 5; f++) frame(f == 2);
        meas <= 1'b1;
        repeat (400) @(posedge sys_clk);
        meas <= 1'b0;
        for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge sys_clk);
        cmp_cnt(rises, 400 / (2 * HC));
        cmp_cnt(exp_q.size(), 0);
        cmp_cnt(frames, 5);
        cmp_cnt(bad, 0);
        cmp_cnt(stalls > 0, 1);
        cmp_cnt(unk, 0);
        end_sim();
    end
endmodule : tb
